// ### hpg_pkg.sv
package hpg_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PWM_HZ = 100;
    localparam int unsigned PWM_STEPS = 100;
    localparam int unsigned SAMPLE_HZ = 32;
    localparam int unsigned PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned DIV_W = 24;

    // Wishbone word offsets (byte address bits 7:2)
    localparam logic [5:0] OFS_REQ_TYPE = 6'h00;
    localparam logic [5:0] OFS_REQ_DATA = 6'h01;
    localparam logic [5:0] OFS_REQ_EXEC = 6'h02;
    localparam logic [5:0] OFS_RSP_STAT = 6'h03;
    localparam logic [5:0] OFS_RSP_DONE = 6'h04;
    localparam logic [5:0] OFS_BAUD = 6'h05;
    localparam logic [5:0] OFS_BOOT_STORE = 6'h06;
    localparam logic [5:0] OFS_BOOT_SNAP = 6'h07;
    localparam logic [1:0] RSP_WIN = 2'h1;

    // Command types and reply marks
    localparam logic [7:0] CMD_STATUS = 8'h1E;
    localparam logic [7:0] CMD_TEXT = 8'h1F;
    localparam logic [7:0] CMD_BAUD = 8'h21;
    localparam logic [7:0] CMD_PIN_SET = 8'h22;
    localparam logic [7:0] CMD_PIN_READ = 8'h23;
    localparam logic [7:0] RSP_ACK_MARK = 8'h40;
    localparam logic [7:0] RSP_ERR_MARK = 8'hC0;
    localparam logic [7:0] WDOG_RUN_BIT = 8'h08;

    // Lengths and limits
    localparam logic [4:0] LEN_STATUS_RSP = 5'h0F;
    localparam logic [4:0] LEN_PIN_RSP = 5'h04;
    localparam logic [4:0] LEN_TEXT_MIN = 5'h03;
    localparam logic [4:0] LEN_TEXT_MAX = 5'h16;
    localparam logic [4:0] LEN_ONE = 5'h01;
    localparam logic [4:0] LEN_TWO = 5'h02;
    localparam logic [4:0] LEN_THREE = 5'h03;
    localparam logic [7:0] COL_MAX = 8'h13;
    localparam logic [7:0] ROW_MAX = 8'h03;
    localparam logic [6:0] LCD_COLS = 7'h14;
    localparam logic [7:0] BAUD_SEL_MAX = 8'h01;
    localparam logic [7:0] PIN_IDX_MAX = 8'h0C;
    localparam logic [7:0] GPIO_IDX_MAX = 8'h04;
    localparam logic [7:0] PIN_VAL_HIGH = 8'h64;
    localparam logic [6:0] PWM_PH_LAST = 7'h63;
    localparam int unsigned NUM_GPIO = 5;
    localparam int unsigned NUM_PINS = 13;
    localparam int unsigned TEXT_DEPTH = 80;

    // Baud selector values
    localparam logic BAUD_19200 = 1'b0;
    localparam logic BAUD_115200 = 1'b1;

    // Drive modes (function bit is bit 3 of the config nibble)
    localparam logic [2:0] DRV_UP_PD = 3'h0;
    localparam logic [2:0] DRV_PUSH_FAST = 3'h1;
    localparam logic [2:0] DRV_HIZ_IN = 3'h2;
    localparam logic [2:0] DRV_PU_DN = 3'h3;
    localparam logic [2:0] DRV_UP_HIZ = 3'h4;
    localparam logic [2:0] DRV_PUSH_SLOW = 3'h5;
    localparam logic [2:0] DRV_RESERVED = 3'h6;
    localparam logic [2:0] DRV_HIZ_DN = 3'h7;
    localparam int unsigned CFG_FUNC_BIT = 3;
    localparam logic [3:0] CFG_RST = 4'h2;
    localparam logic [7:0] VAL_RST = 8'h00;

    // Reply sequencer states
    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_READY = 3'b010,
        RS_BAUD = 3'b100
    } hpg_rsp_state_type;
endpackage

// ### hpg_text_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Character store for the 4x20 display; read data is registered
module hpg_text_mem (
    // Clock
    input wire logic clk_sys,
    // Write port
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_r [0:hpg_pkg::TEXT_DEPTH-1];

    // No reset on the array; the display side tolerates stale text
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
        rd_data <= mem_r[rd_addr];
    end
endmodule // hpg_text_mem
`default_nettype wire

// ### hpg_gpio_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module hpg_gpio_cmd #(
    parameter int unsigned PWM_STEP_CYCLES = hpg_pkg::PWM_STEP_CYC,
    parameter int unsigned SAMPLE_CYCLES = hpg_pkg::SAMPLE_CYC
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Status sources from neighbouring functions
    input wire logic [7:0] rpt_fan_mask,
    input wire logic [31:0] rpt_temp_mask,
    input wire logic [7:0] key_press_mask,
    input wire logic [7:0] key_release_mask,
    input wire logic [7:0] atx_func_mask,
    input wire logic [7:0] wdog_count,
    input wire logic wdog_running,
    input wire logic [31:0] glitch_delay,
    input wire logic [7:0] contrast,
    input wire logic [7:0] backlight,
    // Bidirectional pins
    input wire logic [4:0] gpio_in,
    input wire logic [4:0] dflt_level,
    output logic [4:0] gpio_out,
    output logic [4:0] gpio_oe,
    output logic [4:0] gpio_pu,
    output logic [4:0] gpio_pd,
    output logic [4:0] gpio_slow,
    output logic [4:0] gpio_user,
    // LED dies
    output logic [7:0] output_only_pin,
    // Serial link rate
    output logic baud_sel,
    // Display character read
    input wire logic [6:0] disp_addr,
    output logic [7:0] disp_data
);
    localparam int NG = hpg_pkg::NUM_GPIO;
    localparam int NP = hpg_pkg::NUM_PINS;
    localparam int DW = hpg_pkg::DIV_W;

    logic [7:0] req_type_r, req_b0_r, req_b1_r, req_b2_r;
    logic [4:0] req_cnt_r;
    logic [7:0] pin_val_r [0:NP-1];
    logic [3:0] pin_cfg_r [0:NG-1];
    logic [3:0] snap_cfg_r [0:NG-1];
    logic [NG-1:0] lvl_r, rise_r, fall_r;
    logic [7:0] rsp_type_r, rsp_cmd_r, pr_idx_r, pr_flags_r, pr_val_r, pr_cfg_r;
    logic [4:0] rsp_len_r;
    logic rsp_err_r, baud_pend_r, baud_new_r;
    hpg_pkg::hpg_rsp_state_type rs_r, rs_nxt;
    logic [DW-1:0] pwm_div_r, smp_div_r;
    logic [6:0] pwm_ph_r;

    // Bus decode; every access is answered one cycle after the strobe
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire [5:0] wadr = wb_adr_i[7:2];
    wire wr_type = bus_wr && (wadr == hpg_pkg::OFS_REQ_TYPE);
    wire wr_data = bus_wr && (wadr == hpg_pkg::OFS_REQ_DATA);
    wire wr_exec = bus_wr && (wadr == hpg_pkg::OFS_REQ_EXEC);
    wire wr_done = bus_wr && (wadr == hpg_pkg::OFS_RSP_DONE);
    wire wr_store = bus_wr && (wadr == hpg_pkg::OFS_BOOT_STORE);
    wire [7:0] wbyte = wb_dat_i[7:0];

    // Request validation
    wire [4:0] len = req_cnt_r;
    wire is_status = (req_type_r == hpg_pkg::CMD_STATUS);
    wire is_text = (req_type_r == hpg_pkg::CMD_TEXT);
    wire is_baud = (req_type_r == hpg_pkg::CMD_BAUD);
    wire is_set = (req_type_r == hpg_pkg::CMD_PIN_SET);
    wire is_read = (req_type_r == hpg_pkg::CMD_PIN_READ);
    wire set_cfg_ok = (req_b2_r[7:4] == 4'h0) && (req_b2_r[2:0] != hpg_pkg::DRV_RESERVED);
    wire set_len2 = (len == hpg_pkg::LEN_TWO);
    wire set_len3 = (len == hpg_pkg::LEN_THREE) && set_cfg_ok;
    wire set_ok = is_set && (set_len2 || set_len3) && (req_b0_r <= hpg_pkg::PIN_IDX_MAX)
        && (req_b1_r <= hpg_pkg::PIN_VAL_HIGH);
    wire text_ok = is_text && (len >= hpg_pkg::LEN_TEXT_MIN) && (len <= hpg_pkg::LEN_TEXT_MAX)
        && (req_b0_r <= hpg_pkg::COL_MAX) && (req_b1_r <= hpg_pkg::ROW_MAX);
    wire baud_ok = is_baud && (len == hpg_pkg::LEN_ONE) && (req_b0_r <= hpg_pkg::BAUD_SEL_MAX);
    wire read_ok = is_read && (len == hpg_pkg::LEN_ONE) && (req_b0_r <= hpg_pkg::GPIO_IDX_MAX);
    wire status_ok = is_status && (len == 5'h00);
    wire exec_ok = set_ok || text_ok || baud_ok || read_ok || status_ok;
    wire exec_go = wr_exec && (rs_r != hpg_pkg::RS_BAUD);
    wire [2:0] rd_idx = req_b0_r[2:0];

    // Characters stream straight into the store as they arrive
    wire [4:0] txt_k = req_cnt_r - 5'h02;
    wire [7:0] txt_col = req_b0_r + {3'h0, txt_k};
    wire [6:0] txt_addr = 7'(({5'h00, req_b1_r[1:0]} * hpg_pkg::LCD_COLS) + txt_col[6:0]);
    wire txt_wr = wr_data && is_text && (req_cnt_r >= 5'h02) && (req_cnt_r < hpg_pkg::LEN_TEXT_MAX)
        && (req_b0_r <= hpg_pkg::COL_MAX) && (req_b1_r <= hpg_pkg::ROW_MAX)
        && (txt_col <= hpg_pkg::COL_MAX);

    hpg_text_mem u_text (
        .clk_sys(clk_sys),
        .wr_en(txt_wr),
        .wr_addr(txt_addr),
        .wr_data(wbyte),
        .rd_addr(disp_addr),
        .rd_data(disp_data)
    );

    // Request assembly: type write restarts, data write appends
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_type_r <= 8'h00;
            req_cnt_r <= 5'h00;
            req_b0_r <= 8'h00;
            req_b1_r <= 8'h00;
            req_b2_r <= 8'h00;
        end else if (wr_type) begin
            req_type_r <= wbyte;
            req_cnt_r <= 5'h00;
        end else if (wr_data) begin
            if (req_cnt_r == 5'h00) req_b0_r <= wbyte;
            if (req_cnt_r == 5'h01) req_b1_r <= wbyte;
            if (req_cnt_r == 5'h02) req_b2_r <= wbyte;
            if (req_cnt_r != 5'h1F) req_cnt_r <= req_cnt_r + 5'h01;
        end
    end

    // Reply sequencer; a rate change holds until the reply has gone out
    always_comb begin
        rs_nxt = rs_r;
        case (rs_r)
            hpg_pkg::RS_IDLE, hpg_pkg::RS_READY: begin
                if (exec_go) rs_nxt = (baud_ok) ? hpg_pkg::RS_BAUD : hpg_pkg::RS_READY;
                else if (wr_done) rs_nxt = hpg_pkg::RS_IDLE;
            end
            hpg_pkg::RS_BAUD: begin
                if (wr_done) rs_nxt = hpg_pkg::RS_IDLE;
            end
            default: rs_nxt = hpg_pkg::RS_IDLE;
        endcase
    end

    // Reply latch and rate switch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rs_r <= hpg_pkg::RS_IDLE;
            rsp_type_r <= 8'h00;
            rsp_cmd_r <= 8'h00;
            rsp_len_r <= 5'h00;
            rsp_err_r <= 1'b0;
            baud_new_r <= hpg_pkg::BAUD_115200;
            baud_sel <= hpg_pkg::BAUD_115200;
        end else begin
            rs_r <= rs_nxt;
            if (exec_go) begin
                rsp_type_r <= req_type_r | (exec_ok ? hpg_pkg::RSP_ACK_MARK : hpg_pkg::RSP_ERR_MARK);
                rsp_cmd_r <= req_type_r;
                rsp_err_r <= !exec_ok;
                rsp_len_r <= status_ok ? hpg_pkg::LEN_STATUS_RSP :
                    (read_ok ? hpg_pkg::LEN_PIN_RSP : 5'h00);
                if (baud_ok) baud_new_r <= req_b0_r[0];
            end
            if ((rs_r == hpg_pkg::RS_BAUD) && wr_done) baud_sel <= baud_new_r;
        end
    end
    assign baud_pend_r = (rs_r == hpg_pkg::RS_BAUD);

    // PWM phase 0..99 and the 32 Hz sample strobe
    wire pwm_step = (pwm_div_r == DW'(PWM_STEP_CYCLES - 1));
    wire smp_tick = (smp_div_r == DW'(SAMPLE_CYCLES - 1));
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_div_r <= '0;
            pwm_ph_r <= 7'h00;
            smp_div_r <= '0;
        end else begin
            pwm_div_r <= pwm_step ? '0 : pwm_div_r + DW'(1);
            if (pwm_step) pwm_ph_r <= (pwm_ph_r == hpg_pkg::PWM_PH_LAST) ? 7'h00 : pwm_ph_r + 7'h01;
            smp_div_r <= smp_tick ? '0 : smp_div_r + DW'(1);
        end
    end

    // Per-pin value store; pins 5..12 drive the LED dies
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pin
            wire lvl = (pin_val_r[gi] >= hpg_pkg::PIN_VAL_HIGH) ||
                ((pin_val_r[gi] != 8'h00) && ({1'b0, pwm_ph_r} < pin_val_r[gi]));
            // value written on every accepted set
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pin_val_r[gi] <= hpg_pkg::VAL_RST;
                end else if (exec_go && set_ok && (req_b0_r == 8'(gi))) begin
                    pin_val_r[gi] <= req_b1_r;
                end
            end
            if (gi >= NG) begin : g_gpo
                always_ff @(posedge clk_sys) begin
                    if (rst) output_only_pin[gi-NG] <= 1'b0;
                    else output_only_pin[gi-NG] <= lvl;
                end
            end else begin : g_gpio
                wire [2:0] mode = pin_cfg_r[gi][2:0];
                wire user = pin_cfg_r[gi][hpg_pkg::CFG_FUNC_BIT];
                wire lv = user ? lvl : dflt_level[gi];
                wire drv_hi = lv && ((mode == hpg_pkg::DRV_UP_PD) || (mode == hpg_pkg::DRV_PUSH_FAST)
                    || (mode == hpg_pkg::DRV_UP_HIZ) || (mode == hpg_pkg::DRV_PUSH_SLOW));
                wire drv_lo = !lv && ((mode == hpg_pkg::DRV_PUSH_FAST) || (mode == hpg_pkg::DRV_PU_DN)
                    || (mode == hpg_pkg::DRV_PUSH_SLOW) || (mode == hpg_pkg::DRV_HIZ_DN));
                wire pu = lv && (mode == hpg_pkg::DRV_PU_DN);
                wire pd = !lv && (mode == hpg_pkg::DRV_UP_PD);
                wire slow = (mode == hpg_pkg::DRV_UP_HIZ) || (mode == hpg_pkg::DRV_PUSH_SLOW)
                    || (mode == hpg_pkg::DRV_HIZ_DN);
                wire hit = exec_go && read_ok && (rd_idx == 3'(gi));
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        pin_cfg_r[gi] <= hpg_pkg::CFG_RST;
                        snap_cfg_r[gi] <= hpg_pkg::CFG_RST;
                        gpio_out[gi] <= 1'b0;
                        gpio_oe[gi] <= 1'b0;
                        gpio_pu[gi] <= 1'b0;
                        gpio_pd[gi] <= 1'b0;
                        gpio_slow[gi] <= 1'b0;
                        gpio_user[gi] <= 1'b0;
                    end else begin
                        if (exec_go && set_ok && set_len3 && (req_b0_r == 8'(gi))) begin
                            pin_cfg_r[gi] <= req_b2_r[3:0];
                        end
                        if (wr_store) snap_cfg_r[gi] <= pin_cfg_r[gi];
                        gpio_out[gi] <= drv_hi;
                        gpio_oe[gi] <= drv_hi || drv_lo;
                        gpio_pu[gi] <= pu;
                        gpio_pd[gi] <= pd;
                        gpio_slow[gi] <= slow;
                        gpio_user[gi] <= user;
                    end
                end
                // Edge records; a sample in the query cycle survives the clear
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        lvl_r[gi] <= 1'b0;
                        rise_r[gi] <= 1'b0;
                        fall_r[gi] <= 1'b0;
                    end else begin
                        if (smp_tick) lvl_r[gi] <= gpio_in[gi];
                        rise_r[gi] <= (smp_tick && gpio_in[gi] && !lvl_r[gi]) || (rise_r[gi] && !hit);
                        fall_r[gi] <= (smp_tick && !gpio_in[gi] && lvl_r[gi]) || (fall_r[gi] && !hit);
                    end
                end
            end
        end
    endgenerate

    // Pin read reply captured at execution, before the records clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pr_idx_r <= 8'h00;
            pr_flags_r <= 8'h00;
            pr_val_r <= 8'h00;
            pr_cfg_r <= 8'h00;
        end else if (exec_go && read_ok) begin
            pr_idx_r <= req_b0_r;
            pr_flags_r <= {5'h00, rise_r[rd_idx], fall_r[rd_idx], lvl_r[rd_idx]};
            pr_val_r <= pin_val_r[rd_idx];
            pr_cfg_r <= {4'h0, pin_cfg_r[rd_idx]};
        end
    end

    // Reply byte selection; status bytes read live from their sources
    wire [3:0] ri = wb_adr_i[5:2];
    logic [7:0] st_byte;
    always_comb begin
        case (ri)
            4'h0: st_byte = rpt_fan_mask;
            4'h1: st_byte = rpt_temp_mask[7:0];
            4'h2: st_byte = rpt_temp_mask[15:8];
            4'h3: st_byte = rpt_temp_mask[23:16];
            4'h4: st_byte = rpt_temp_mask[31:24];
            4'h5: st_byte = key_press_mask;
            4'h6: st_byte = key_release_mask;
            4'h7: st_byte = atx_func_mask | (wdog_running ? hpg_pkg::WDOG_RUN_BIT : 8'h00);
            4'h8: st_byte = wdog_count;
            4'h9: st_byte = glitch_delay[7:0];
            4'hA: st_byte = glitch_delay[15:8];
            4'hB: st_byte = glitch_delay[23:16];
            4'hC: st_byte = glitch_delay[31:24];
            4'hD: st_byte = contrast;
            4'hE: st_byte = backlight;
            default: st_byte = 8'h00;
        endcase
    end
    wire [7:0] pr_byte = (ri == 4'h0) ? pr_idx_r : (ri == 4'h1) ? pr_flags_r :
        (ri == 4'h2) ? pr_val_r : (ri == 4'h3) ? pr_cfg_r : 8'h00;
    wire rsp_live = (rs_r != hpg_pkg::RS_IDLE) && ({1'b0, ri} < rsp_len_r);
    wire [7:0] rsp_byte = !rsp_live ? 8'h00 :
        (rsp_cmd_r == hpg_pkg::CMD_STATUS) ? st_byte : pr_byte;
    wire [31:0] snap_word = {16'h0000, snap_cfg_r[3], snap_cfg_r[2], snap_cfg_r[1], snap_cfg_r[0]};
    wire [31:0] rd_mux =
        (wb_adr_i[7:6] == hpg_pkg::RSP_WIN) ? {24'h0000_00, rsp_byte} :
        (wadr == hpg_pkg::OFS_REQ_TYPE) ? {24'h0000_00, req_type_r} :
        (wadr == hpg_pkg::OFS_REQ_DATA) ? {27'h000_0000, req_cnt_r} :
        (wadr == hpg_pkg::OFS_RSP_STAT) ? {8'h00, 3'h0, rsp_len_r, rsp_type_r,
            5'h00, baud_pend_r, rsp_err_r, rs_r != hpg_pkg::RS_IDLE} :
        (wadr == hpg_pkg::OFS_BAUD) ? {30'h0000_0000, baud_pend_r, baud_sel} :
        (wadr == hpg_pkg::OFS_BOOT_SNAP) ? (snap_word | {12'h000, snap_cfg_r[4], 16'h0000}) :
        32'h0000_0000;

    // Bus answer: ack one cycle after the strobe, dropped the next
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // Checks
    sequence s_exec_read;
        exec_go && read_ok && !smp_tick;
    endsequence
    sequence s_exec_bad_set;
        exec_go && is_set && !set_ok;
    endsequence

    a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single cycle pulse");
    a_baud_after_ack: assert property (@(posedge clk_sys) disable iff (rst)
        (baud_sel != $past(baud_sel)) |-> $past(wr_done) && $past(baud_pend_r))
        else $error("rate changed before reply sent");
    a_baud_reset_fast: assert property (@(posedge clk_sys)
        $past(rst) && !rst |-> baud_sel == hpg_pkg::BAUD_115200)
        else $error("rate not fast after reset");
    a_reply_mark: assert property (@(posedge clk_sys) disable iff (rst)
        exec_go && exec_ok |=> rsp_type_r == ($past(req_type_r) | hpg_pkg::RSP_ACK_MARK))
        else $error("reply type lacks ack mark");
    a_edges_cleared: assert property (@(posedge clk_sys) disable iff (rst)
        s_exec_read |=> !rise_r[pr_idx_r[2:0]] && !fall_r[pr_idx_r[2:0]])
        else $error("edge records not cleared");
    a_bad_set_kept: assert property (@(posedge clk_sys) disable iff (rst)
        s_exec_bad_set |=> $stable(pin_cfg_r[0]) && $stable(pin_cfg_r[4]) && $stable(pin_val_r[5]))
        else $error("rejected set altered a pin");
    a_flags_echo: assert property (@(posedge clk_sys) disable iff (rst)
        s_exec_read |=> pr_flags_r[0] == $past(lvl_r[rd_idx]) && pr_idx_r == $past(req_b0_r))
        else $error("pin read reply wrong");
    a_led_full_high: assert property (@(posedge clk_sys) disable iff (rst)
        (pin_val_r[5] == hpg_pkg::PIN_VAL_HIGH)[*2] |-> output_only_pin[0])
        else $error("value 100 not constant high");
    a_led_zero_low: assert property (@(posedge clk_sys) disable iff (rst)
        (pin_val_r[6] == 8'h00)[*2] |-> !output_only_pin[1])
        else $error("value 0 not constant low");
    a_status_wdog: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req && !wb_we_i && rsp_live && (rsp_cmd_r == hpg_pkg::CMD_STATUS) && (ri == 4'h7)
        && (wb_adr_i[7:6] == hpg_pkg::RSP_WIN) && wdog_running |=> wb_dat_o[3])
        else $error("watchdog bit missing");
endmodule // hpg_gpio_cmd
`default_nettype wire

// ### hpg_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side pad model: a driven pin wins, then the pulls, else the external level
module hpg_pin_load (
    // Pad controls from the block
    input wire logic [4:0] drv,
    input wire logic [4:0] oe,
    input wire logic [4:0] pu,
    input wire logic [4:0] pd,
    // External level and resolved wire
    input wire logic [4:0] ext,
    output logic [4:0] lvl
);
    // Wire level with pull resistors weaker than any driver
    assign lvl = (oe & drv) | (~oe & pu) | (~oe & ~pu & ~pd & ext);
endmodule // hpg_pin_load
`default_nettype wire

// ### test_host_packet_gpio_commands.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_packet_gpio_commands;
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, wdr = 0, ack, bsel;
    logic [7:0] adr = 0, atx = 0, wdc = 0, ch, li, led, dd;
    logic [31:0] dat = 0, tmp = 0, q, dout;
    logic [4:0] gin, go, oe, pu, pd, sl, us, ext = 0;
    logic [6:0] da = 0;
    logic [7:0] bi [4] = '{8'h0D, 8'h00, 8'h00, 8'h00}, bv [4] = '{8'h00, 8'h65, 8'h00, 8'h00};
    logic [7:0] bc [4] = '{8'h02, 8'h02, 8'h06, 8'h12};
    int err_count = 0, cmp_count = 0, n = 0;
    localparam int STEP = 4;
    // Clock
    always #5 clk_sys = ~clk_sys;
    hpg_gpio_cmd #(.PWM_STEP_CYCLES(STEP), .SAMPLE_CYCLES(20)) dut (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .rpt_fan_mask(atx ^ 8'h5A),
        .rpt_temp_mask(tmp), .key_press_mask(wdc), .key_release_mask(~wdc), .atx_func_mask(atx),
        .wdog_count(wdc), .wdog_running(wdr), .glitch_delay(~tmp), .contrast(8'h00),
        .backlight(atx), .gpio_in(gin), .dflt_level(5'h00), .gpio_out(go), .gpio_oe(oe),
        .gpio_pu(pu), .gpio_pd(pd), .gpio_slow(sl), .gpio_user(us), .output_only_pin(led),
        .baud_sel(bsel), .disp_addr(da), .disp_data(dd));
    hpg_pin_load pins (.drv(go), .oe(oe), .pu(pu), .pd(pd), .ext(ext), .lvl(gin));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // High cycles in one full PWM period for a given duty value
    function automatic int pwm_hi(input int duty);
        return duty * STEP;
    endfunction
    task automatic wrap_up;
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Release old reply, assemble, execute, read reply status
    task automatic req(input logic [7:0] t, input int n, input logic [7:0] b0, b1, b2);
        bus(1'b1, 8'h10, 8'h00);
        bus(1'b1, 8'h00, t);
        if (n > 0) bus(1'b1, 8'h04, b0);
        if (n > 1) bus(1'b1, 8'h04, b1);
        if (n > 2) bus(1'b1, 8'h04, b2);
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b0, 8'h0C, 8'h00);
    endtask
    // Pin read of pin 0; e holds the four reply bytes, byte 0 lowest
    task automatic pin_rd(input logic [31:0] e);
        repeat (60) @(posedge clk_sys);
        req(8'h23, 1, 8'h00, 8'h00, 8'h00);
        chk(q[20:8], {5'h04, 8'h63});
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(8'h40 + 4 * i), 8'h00);
            chk(q[7:0], e[8*i +: 8]);
        end
    endtask
    initial begin
        void'($urandom(20179));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Status reply with random sources and both watchdog states
        for (int i = 0; i < 4; i++) begin
            atx <= 8'($urandom);
            tmp <= $urandom;
            wdr <= i[0];
            req(8'h1E, 0, 8'h00, 8'h00, 8'h00);
            chk(q[20:8], {5'h0F, 8'h5E});
            bus(1'b0, 8'h5C, 8'h00);
            chk(q[7:0], atx | {4'h0, wdr, 3'h0});
            bus(1'b0, 8'h44, 8'h00);
            chk(q[7:0], tmp[7:0]);
        end
        // Rate change: old rate until the reply is released
        chk(bsel, 1'b1);
        for (int s = 0; s < 2; s++) begin
            req(8'h21, 1, 8'(s), 8'h00, 8'h00);
            chk(bsel, s == 0);
            bus(1'b1, 8'h10, 8'h00);
            repeat (3) @(posedge clk_sys);
            chk(bsel, s == 1);
        end
        // Refused pin settings leave the pin untouched
        for (int i = 0; i < 4; i++) begin
            req(8'h22, 3, bi[i], bv[i], bc[i]);
            chk(q[20:1], {5'h00, 8'hE2, 7'h01});
        end
        req(8'h23, 1, 8'h05, 8'h00, 8'h00);
        chk(q[15:8], 8'hE3);
        pin_rd(32'h0200_0000);
        req(8'h22, 3, 8'h00, 8'h64, 8'h09);
        repeat (3) @(posedge clk_sys);
        chk({go[0], oe[0]}, 2'h3);
        pin_rd(32'h0964_0500);
        pin_rd(32'h0964_0100);
        req(8'h22, 2, 8'h00, 8'h00, 8'h00);
        pin_rd(32'h0900_0200);
        // Hi-Z user pin reports the pad, not the commanded value
        req(8'h22, 3, 8'h00, 8'h64, 8'h0A);
        chk({us[0], sl[0], oe[0]}, 3'h4);
        pin_rd(32'h0A64_0000);
        ext <= 5'h01;
        pin_rd(32'h0A64_0500);
        // Boot store snapshot of all five nibbles
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b0, 8'h1C, 8'h00);
        chk(q, 32'h0002_222A);
        // Random LED die driven high
        li = 8'(5 + $urandom % 8);
        req(8'h22, 2, li, 8'h64, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk(led[li - 8'h05], 1'b1);
        // Pin 5 held high; pin 7 at half duty over one full period
        req(8'h22, 2, 8'h05, 8'h64, 8'h00);
        req(8'h22, 2, 8'h07, 8'h32, 8'h00);
        chk(led[0], 1'b1);
        n = 0;
        repeat (100 * STEP) begin
            @(posedge clk_sys);
            n += led[2];
        end
        chk(n, pwm_hi(50));
        // Text at the last column of the last row
        ch = 8'($urandom);
        req(8'h1F, 3, 8'h13, 8'h03, ch);
        da <= 7'h4F;
        repeat (3) @(posedge clk_sys);
        chk(dd, ch);
        wrap_up();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
endmodule // test_host_packet_gpio_commands
`default_nettype wire
